// ### rtl/index_output_override.sv
// Index status outputs and analog velocity override with an AXI4-Lite register slave.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps

module index_output_override (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] op_mode,
  input wire logic servo_on_input,
  input wire logic index_start,
  input wire logic [5:0] index_start_num,
  input wire logic index_done,
  input wire logic signed [31:0] demand_pos,
  input wire logic signed [31:0] actual_pos,
  input wire logic signed [31:0] target_pos,
  input wire logic [15:0] analog_speed_input,
  input wire logic [31:0] index_velocity,
  output logic sequence_end_flag,
  output logic [5:0] index_number_out,
  output logic [31:0] override_velocity,
  output logic irq
);

  // --------------------------------------------------------------------------
  // Register file and bus state
  // --------------------------------------------------------------------------
  logic [15:0] ovr_mode_ff, nxt_ovr_mode;
  logic [15:0] ovr_offset_ff, nxt_ovr_offset;
  logic [15:0] out_cfg_ff, nxt_out_cfg;
  logic [2:0] irq_status_ff, nxt_irq_status;
  logic [2:0] irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [17:0] waddr_ff, nxt_waddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic status_read;

  // --------------------------------------------------------------------------
  // Index tracking state
  // --------------------------------------------------------------------------
  index_output_pkg::idx_state_t state_ff, nxt_state;
  logic [5:0] out_num_ff, nxt_out_num;
  logic [5:0] run_num_ff, nxt_run_num;
  logic seq_end_ff, nxt_seq_end;
  logic [3:0] op_mode_ff, nxt_op_mode;
  logic srv_meta_ff, srv_sync_ff, srv_prev_ff;
  logic reinit;
  logic demand_reached;
  logic [2:0] events;
  logic [31:0] scaled_velocity;
  logic [15:0] active_factor;

  function automatic logic [15:0] merge16(input logic [15:0] old_val, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old_val[15:8], strb[0] ? data[7:0] : old_val[7:0]};
  endfunction : merge16

  function automatic logic [17:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // --------------------------------------------------------------------------
  // Servo-on synchroniser and reinitialisation
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srv_meta_ff <= 1'b0;
      srv_sync_ff <= 1'b0;
      srv_prev_ff <= 1'b0;
    end else begin
      srv_meta_ff <= servo_on_input;
      srv_sync_ff <= srv_meta_ff;
      srv_prev_ff <= srv_sync_ff;
    end
  end

  // The previous mode is loaded with the live one each cycle, so a change is seen once.
  assign nxt_op_mode = op_mode;
  assign reinit = (op_mode != op_mode_ff) || (srv_prev_ff && !srv_sync_ff);
  assign demand_reached = (demand_pos == target_pos) && (actual_pos != target_pos)
    && (target_pos >= 32'sh0000_0000) && (target_pos <= index_output_pkg::MOVE_LIMIT_USER);

  // --------------------------------------------------------------------------
  // Index number and end-of-sequence outputs
  // --------------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_out_num = out_num_ff;
    nxt_run_num = run_num_ff;
    nxt_seq_end = seq_end_ff;
    if (reinit) begin
      nxt_state = index_output_pkg::IDX_IDLE;
      nxt_out_num = index_output_pkg::INDEX_NUM_RST;
      nxt_run_num = index_output_pkg::INDEX_NUM_RST;
      nxt_seq_end = 1'b0;
    end else begin
      unique case (state_ff)
        index_output_pkg::IDX_IDLE: begin
          if (index_start) begin
            nxt_state = index_output_pkg::IDX_RUN;
            nxt_run_num = index_start_num;
            nxt_seq_end = 1'b0;
            if (out_cfg_ff == index_output_pkg::CFG_SHOW_RUNNING) begin
              nxt_out_num = index_start_num;
            end
            // Any other setting leaves the last completed number standing.
          end
        end
        index_output_pkg::IDX_RUN: begin
          if (index_done) begin
            nxt_state = index_output_pkg::IDX_IDLE;
            nxt_out_num = run_num_ff;
            nxt_seq_end = 1'b1;
          end else if (demand_reached) begin
            nxt_seq_end = 1'b1;
          end
        end
        default: begin
          nxt_state = index_output_pkg::IDX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= index_output_pkg::IDX_IDLE;
      out_num_ff <= index_output_pkg::INDEX_NUM_RST;
      run_num_ff <= index_output_pkg::INDEX_NUM_RST;
      seq_end_ff <= 1'b0;
      op_mode_ff <= index_output_pkg::OP_MODE_INDEXING;
    end else begin
      state_ff <= nxt_state;
      out_num_ff <= nxt_out_num;
      run_num_ff <= nxt_run_num;
      seq_end_ff <= nxt_seq_end;
      op_mode_ff <= nxt_op_mode;
    end
  end

  // --------------------------------------------------------------------------
  // Velocity override
  // --------------------------------------------------------------------------
  velocity_override_scale u_scale (
    .clk(clk),
    .sys_rst(sys_rst),
    .apply(op_mode == index_output_pkg::OP_MODE_INDEXING),
    .mode(ovr_mode_ff),
    .offset_mv(ovr_offset_ff),
    .analog_mv(analog_speed_input),
    .base_velocity(index_velocity),
    .velocity_ff(scaled_velocity),
    .factor_ff(active_factor)
  );

  // --------------------------------------------------------------------------
  // AXI4-Lite slave, sticky status and interrupt
  // --------------------------------------------------------------------------
  assign events = {reinit, (state_ff == index_output_pkg::IDX_RUN) && index_done && !reinit,
                   nxt_seq_end && !seq_end_ff};
  assign status_read = s_axi_arvalid && arready_ff
    && s_axi_araddr == byte_addr(index_output_pkg::IDX_IRQ_STATUS);

  always_comb begin
    nxt_awready = awready_ff;
    nxt_wready = wready_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_waddr = waddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_ovr_mode = ovr_mode_ff;
    nxt_ovr_offset = ovr_offset_ff;
    nxt_out_cfg = out_cfg_ff;
    nxt_irq_mask = irq_mask_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_waddr = s_axi_awaddr;
      nxt_awready = 1'b0;
    end
    if (s_axi_wvalid && wready_ff) begin
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
      nxt_wready = 1'b0;
    end
    if (!awready_ff && !wready_ff && !bvalid_ff) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = index_output_pkg::RESP_OKAY;
      unique case (waddr_ff)
        byte_addr(index_output_pkg::IDX_OVR_MODE):
          nxt_ovr_mode = merge16(ovr_mode_ff, wdata_ff, wstrb_ff);
        byte_addr(index_output_pkg::IDX_OVR_OFFSET):
          nxt_ovr_offset = merge16(ovr_offset_ff, wdata_ff, wstrb_ff);
        byte_addr(index_output_pkg::IDX_OUT_CFG):
          nxt_out_cfg = merge16(out_cfg_ff, wdata_ff, wstrb_ff);
        byte_addr(index_output_pkg::IDX_IRQ_MASK): begin
          if (wstrb_ff[0]) begin
            nxt_irq_mask = wdata_ff[2:0];
          end
        end
        byte_addr(index_output_pkg::IDX_IRQ_STATUS), byte_addr(index_output_pkg::IDX_BLOCK_STATE): begin
        end
        default: nxt_bresp = index_output_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
  end

  always_comb begin
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    // A read clears the sticky bits, but an event in the same cycle still lands.
    nxt_irq_status = (status_read ? 3'h0 : irq_status_ff) | events;
    nxt_irq = |(nxt_irq_status & irq_mask_ff);
    if (s_axi_arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = index_output_pkg::RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        byte_addr(index_output_pkg::IDX_OVR_MODE): nxt_rdata[15:0] = ovr_mode_ff;
        byte_addr(index_output_pkg::IDX_OVR_OFFSET): nxt_rdata[15:0] = ovr_offset_ff;
        byte_addr(index_output_pkg::IDX_OUT_CFG): nxt_rdata[15:0] = out_cfg_ff;
        byte_addr(index_output_pkg::IDX_IRQ_STATUS): nxt_rdata[2:0] = irq_status_ff;
        byte_addr(index_output_pkg::IDX_IRQ_MASK): nxt_rdata[2:0] = irq_mask_ff;
        byte_addr(index_output_pkg::IDX_BLOCK_STATE):
          nxt_rdata = {active_factor, 2'b00, state_ff, run_num_ff[4:0], seq_end_ff, out_num_ff};
        default: nxt_rresp = index_output_pkg::RESP_SLVERR;
      endcase
    end
    if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= index_output_pkg::RESP_OKAY;
      waddr_ff <= 18'h0_0000;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= index_output_pkg::RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      ovr_mode_ff <= index_output_pkg::OVR_MODE_RST;
      ovr_offset_ff <= index_output_pkg::OVR_OFFSET_RST;
      out_cfg_ff <= index_output_pkg::OUT_CFG_RST;
      irq_mask_ff <= index_output_pkg::IRQ_MASK_RST;
      irq_status_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      waddr_ff <= nxt_waddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      ovr_mode_ff <= nxt_ovr_mode;
      ovr_offset_ff <= nxt_ovr_offset;
      out_cfg_ff <= nxt_out_cfg;
      irq_mask_ff <= nxt_irq_mask;
      irq_status_ff <= nxt_irq_status;
      irq_ff <= nxt_irq;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign sequence_end_flag = seq_end_ff;
  assign index_number_out = out_num_ff;
  assign override_velocity = scaled_velocity;
  assign irq = irq_ff;

endmodule : index_output_override

// ### rtl/index_output_pkg.sv
// Constants, register map and types for the index output and velocity override block.
package index_output_pkg;

  // --------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------------
  localparam logic [15:0] IDX_OVR_MODE = 16'h220F;
  localparam logic [15:0] IDX_OVR_OFFSET = 16'h2215;
  localparam logic [15:0] IDX_OUT_CFG = 16'h300A;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h3100;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h3101;
  localparam logic [15:0] IDX_BLOCK_STATE = 16'h3102;
  localparam int ADDR_W = 18;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] OVR_MODE_RST = 16'h0000;
  localparam logic [15:0] OVR_OFFSET_RST = 16'h0000;
  localparam logic [15:0] OUT_CFG_RST = 16'h0000;
  localparam logic [2:0] IRQ_MASK_RST = 3'h0;
  localparam logic [5:0] INDEX_NUM_RST = 6'h00;

  // --------------------------------------------------------------------------
  // Field codes and positions
  // --------------------------------------------------------------------------
  localparam logic [15:0] OVR_OFF = 16'h0000;
  localparam logic [15:0] OVR_BIPOLAR = 16'h0001;
  localparam logic [15:0] OVR_UNIPOLAR = 16'h0002;
  localparam logic [15:0] CFG_SHOW_RUNNING = 16'h0000;
  localparam logic [3:0] OP_MODE_INDEXING = 4'h2;
  localparam int IRQ_END_FLAG = 0;
  localparam int IRQ_DONE = 1;
  localparam int IRQ_REINIT = 2;
  localparam int IRQ_W = 3;

  // --------------------------------------------------------------------------
  // Position and analog limits
  // --------------------------------------------------------------------------
  localparam logic signed [31:0] MOVE_LIMIT_USER = 32'sh0320_0000;
  localparam logic signed [17:0] SPAN_MV = 18'sh0_2710;
  localparam logic [31:0] FACTOR_UNITY = 32'h0000_2710;

  // --------------------------------------------------------------------------
  // Bus answers
  // --------------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    IDX_IDLE = 2'b01,
    IDX_RUN = 2'b10
  } idx_state_t;

endpackage : index_output_pkg

// ### rtl/velocity_override_scale.sv
// Scales the index velocity by the offset-corrected analog override voltage.
`timescale 1ns/100ps
module velocity_override_scale (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic apply,
  input wire logic [15:0] mode,
  input wire logic [15:0] offset_mv,
  input wire logic [15:0] analog_mv,
  input wire logic [31:0] base_velocity,
  output logic [31:0] velocity_ff,
  output logic [15:0] factor_ff
);

  logic signed [17:0] volts_mv;
  logic signed [17:0] clamped_mv;
  logic [31:0] factor;
  logic [63:0] product;
  logic [31:0] nxt_velocity;
  logic [15:0] nxt_factor;

  always_comb begin
    volts_mv = $signed({{2{analog_mv[15]}}, analog_mv})
      + $signed({{2{offset_mv[15]}}, offset_mv});
    clamped_mv = volts_mv;
    factor = index_output_pkg::FACTOR_UNITY;
    if (mode == index_output_pkg::OVR_UNIPOLAR) begin
      // Below 0 V the unipolar range has nothing to say, so it pins at 0 %.
      if (volts_mv < 18'sh0_0000) begin
        clamped_mv = 18'sh0_0000;
      end else if (volts_mv > index_output_pkg::SPAN_MV) begin
        clamped_mv = index_output_pkg::SPAN_MV;
      end
      factor = 32'(clamped_mv) << 1;
    end else begin
      if (volts_mv < -index_output_pkg::SPAN_MV) begin
        clamped_mv = -index_output_pkg::SPAN_MV;
      end else if (volts_mv > index_output_pkg::SPAN_MV) begin
        clamped_mv = index_output_pkg::SPAN_MV;
      end
      factor = 32'(clamped_mv + index_output_pkg::SPAN_MV);
    end
    if (!apply || mode == index_output_pkg::OVR_OFF ||
        (mode != index_output_pkg::OVR_BIPOLAR && mode != index_output_pkg::OVR_UNIPOLAR)) begin
      factor = index_output_pkg::FACTOR_UNITY;
    end
    product = {32'h0000_0000, base_velocity} * {32'h0000_0000, factor};
    nxt_velocity = 32'(product / {32'h0000_0000, index_output_pkg::FACTOR_UNITY});
    nxt_factor = factor[15:0];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      velocity_ff <= 32'h0000_0000;
      factor_ff <= 16'h0000;
    end else begin
      velocity_ff <= nxt_velocity;
      factor_ff <= nxt_factor;
    end
  end

endmodule : velocity_override_scale

// ### tb/index_output_props.sv
// Checker for the index outputs, the override bypass and bus answer timing.
`timescale 1ns/100ps
module index_output_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] op_mode,
  input wire logic servo_on_input,
  input wire logic index_start,
  input wire logic [5:0] index_start_num,
  input wire logic index_done,
  input wire logic signed [31:0] demand_pos,
  input wire logic signed [31:0] actual_pos,
  input wire logic signed [31:0] target_pos,
  input wire logic [31:0] index_velocity,
  input wire logic sequence_end_flag,
  input wire logic [5:0] index_number_out,
  input wire logic [31:0] override_velocity
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // --------------------------------------------------------------------------
  // Shadow of the run state
  // --------------------------------------------------------------------------
  // The run-state checks pause until the servo input has been steady high for a while, since the
  // servo reinit lands a few edges after its fall.
  logic [3:0] mode_prev_ff, nxt_mode_prev, srv_ff, nxt_srv;
  logic run_ff, nxt_run, reinit, ok_srv;
  logic [5:0] num_ff, nxt_num;
  assign reinit = op_mode != mode_prev_ff;
  assign ok_srv = (&srv_ff) && servo_on_input;
  always_comb begin
    nxt_mode_prev = op_mode;
    nxt_srv = {srv_ff[2:0], servo_on_input};
    nxt_run = run_ff;
    nxt_num = num_ff;
    if (reinit || !ok_srv) begin
      nxt_run = 1'b0;
    end else if (!run_ff && index_start) begin
      nxt_run = 1'b1;
      nxt_num = index_start_num;
    end else if (run_ff && index_done) begin
      nxt_run = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_prev_ff <= index_output_pkg::OP_MODE_INDEXING;
      srv_ff <= 4'h0;
      run_ff <= 1'b0;
      num_ff <= 6'h00;
    end else begin
      mode_prev_ff <= nxt_mode_prev;
      srv_ff <= nxt_srv;
      run_ff <= nxt_run;
      num_ff <= nxt_num;
    end
  end
  sequence s_done_taken;
    run_ff && index_done && !reinit && ok_srv;
  endsequence
  sequence s_start_taken;
    !run_ff && index_start && !reinit && ok_srv;
  endsequence
  chk_done_flag: assert property (s_done_taken |=> sequence_end_flag)
    else $error("end flag missing after index done");
  chk_done_number: assert property (s_done_taken |=> index_number_out == num_ff)
    else $error("completed index number not shown");
  chk_start_clear: assert property (s_start_taken |=> !sequence_end_flag)
    else $error("end flag not cleared by start");
  chk_demand_flag: assert property (run_ff && ok_srv && !reinit && demand_pos == target_pos
    && actual_pos != target_pos && target_pos >= 0
    && target_pos <= index_output_pkg::MOVE_LIMIT_USER |=> sequence_end_flag)
    else $error("end flag missing on demand reach");
  chk_mode_reinit: assert property (reinit |=> index_number_out == 6'h00 && !sequence_end_flag)
    else $error("outputs not reinitialised on mode change");
  chk_ovr_bypass: assert property (op_mode != index_output_pkg::OP_MODE_INDEXING
    |=> override_velocity == $past(index_velocity))
    else $error("velocity scaled outside indexing");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule : index_output_props

bind index_output_override index_output_props chk_i (.*);

// ### tb/index_host_model.sv
// Upper controller model that starts an index and reports it done after a gap.
`timescale 1ns/100ps
module index_host_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic go,
  input wire logic [5:0] num,
  input wire logic [7:0] gap,
  output logic index_start,
  output logic [5:0] index_start_num,
  output logic index_done
);
  logic [7:0] cnt_ff, nxt_cnt;
  logic start_ff, nxt_start, done_ff, nxt_done;
  logic [5:0] num_ff, nxt_num;
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_start = 1'b0;
    nxt_done = 1'b0;
    nxt_num = num_ff;
    if (go) begin
      // The number is taken from num as given; the bench never starts index 0, so a reinit stays distinguishable.
      nxt_num = num;
      nxt_cnt = gap;
      nxt_start = 1'b1;
    end else if (cnt_ff != 8'h00) begin
      nxt_cnt = cnt_ff - 8'h01;
      nxt_done = cnt_ff == 8'h01;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 8'h00;
      start_ff <= 1'b0;
      done_ff <= 1'b0;
      num_ff <= 6'h00;
    end else begin
      cnt_ff <= nxt_cnt;
      start_ff <= nxt_start;
      done_ff <= nxt_done;
      num_ff <= nxt_num;
    end
  end
  assign index_start = start_ff;
  assign index_start_num = num_ff;
  assign index_done = done_ff;
endmodule : index_host_model

// ### tb/testbench.sv
// Self-checking bench for the index output and velocity override block.
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, irq, sequence_end_flag;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, index_start, index_done, servo_on_input = 1'b1;
  logic [17:0] s_axi_awaddr = 18'h00000, s_axi_araddr = 18'h00000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, override_velocity;
  logic [31:0] index_velocity = 32'h3E8, rd;
  logic [3:0] s_axi_wstrb = 4'hF, op_mode = 4'h2;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] index_start_num, index_number_out, num = 6'h00;
  logic [7:0] gap = 8'h08;
  logic signed [31:0] demand_pos = 32'sh0, actual_pos = 32'sh0, target_pos = 32'sh0;
  logic [15:0] analog_speed_input = 16'h0000;
  int err_total = 0, check_count = 0, cyc = 0;
  typedef struct {logic [15:0] mode, off, mv; logic [31:0] vel;} ovr_row_t;
  ovr_row_t rows[9] = '{'{16'h0, 16'h0, 16'h1388, 32'h3E8}, '{16'h1, 16'h0, 16'hD8F0, 32'h0},
    '{16'h1, 16'h0, 16'h0, 32'h3E8}, '{16'h1, 16'h0, 16'h2710, 32'h7D0},
    '{16'h1, 16'h1F4, 16'h7D0, 32'h4E2}, '{16'h2, 16'h0, 16'h1388, 32'h3E8},
    '{16'h2, 16'h0, 16'h2710, 32'h7D0}, '{16'h2, 16'h0, 16'hF448, 32'h0},
    '{16'h1, 16'hFC18, 16'h0, 32'h384}};
  index_output_override dut (.*);
  index_host_model host (.clk(clk), .sys_rst(sys_rst), .go(go), .num(num), .gap(gap),
    .index_start(index_start), .index_start_num(index_start_num), .index_done(index_done));
  always #2 clk = ~clk;
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  function automatic logic [17:0] ba(input logic [15:0] idx);
    return {idx, 2'b00};
  endfunction : ba
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bit ad = 0, wd = 0;
    @(posedge clk);
    s_axi_awaddr <= ba(idx);
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && s_axi_awready === 1'b1) begin ad = 1; s_axi_awvalid <= 1'b0; end
      if (!wd && s_axi_wready === 1'b1) begin wd = 1; s_axi_wvalid <= 1'b0; end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, 32'h0);
  endtask : wr
  task automatic rdr(input logic [17:0] a, output logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    // Ready follows valid, so the slave must hold its answer for one more edge.
    s_axi_rready <= 1'b1;
    @(posedge clk);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
  endtask : rdr
  task automatic run_index(input logic [5:0] n, input logic [7:0] g);
    @(posedge clk);
    num <= n;
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : run_index
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rdr(ba(index_output_pkg::IDX_OUT_CFG), rd, 2'h0);
    chk("cfg reset", rd, 32'h0);
    rdr(ba(index_output_pkg::IDX_OVR_MODE), rd, 2'h0);
    chk("mode reset", rd, 32'h0);
    rdr(18'h00010, rd, 2'h2);
    chk("unmapped", rd, 32'h0);
    $display("register test done");
    foreach (rows[i]) begin
      wr(index_output_pkg::IDX_OVR_MODE, {16'h0, rows[i].mode});
      wr(index_output_pkg::IDX_OVR_OFFSET, {16'h0, rows[i].off});
      analog_speed_input <= rows[i].mv;
      repeat (3) @(posedge clk);
      chk("override", override_velocity, rows[i].vel);
    end
    rdr(ba(index_output_pkg::IDX_BLOCK_STATE), rd, 2'h0);
    chk("block state", rd, 32'h2328_1000);
    $display("override table done");
    run_index(6'h05, 8'h08);
    chk("running num", {26'h0, index_number_out}, 32'h5);
    repeat (10) @(posedge clk);
    chk("end flag", {31'h0, sequence_end_flag}, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rdr(ba(index_output_pkg::IDX_IRQ_STATUS), rd, 2'h0);
    chk("first status", rd, 32'h3);
    wr(index_output_pkg::IDX_OUT_CFG, 32'h1);
    wr(index_output_pkg::IDX_IRQ_MASK, 32'h1);
    run_index(6'h07, 8'h08);
    chk("prev num", {26'h0, index_number_out}, 32'h5);
    chk("flag cleared", {31'h0, sequence_end_flag}, 32'h0);
    repeat (10) @(posedge clk);
    chk("done num", {26'h0, index_number_out}, 32'h7);
    chk("irq up", {31'h0, irq}, 32'h1);
    rdr(ba(index_output_pkg::IDX_IRQ_STATUS), rd, 2'h0);
    chk("status", rd, 32'h3);
    repeat (2) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("index output test done");
    wr(index_output_pkg::IDX_OUT_CFG, 32'h0);
    target_pos <= 32'sh3E8;
    run_index(6'h09, 8'h20);
    demand_pos <= 32'sh3E8;
    repeat (3) @(posedge clk);
    chk("demand flag", {31'h0, sequence_end_flag}, 32'h1);
    repeat (40) @(posedge clk);
    op_mode <= 4'h1;
    repeat (3) @(posedge clk);
    chk("mode reinit", {25'h0, sequence_end_flag, index_number_out}, 32'h0);
    chk("no override", override_velocity, 32'h3E8);
    op_mode <= 4'h2;
    run_index(6'h0B, 8'h08);
    servo_on_input <= 1'b0;
    repeat (8) @(posedge clk);
    chk("servo reinit", {26'h0, index_number_out}, 32'h0);
    servo_on_input <= 1'b1;
    $display("reinit test done");
    close_out();
  end
endmodule : testbench
